// File: include/spi_port_regs.vh
`ifndef SPI_PORT_REGS_VH
`define SPI_PORT_REGS_VH

// header layout
`define SHORT_ADDR_W     6
`define LONG_ADDR_W      10
`define SHORT_HDR_BITS   8
`define LONG_HDR_BITS    12
`define DATA_BITS        8
`define FRAME_BITS_SHORT 16
`define FRAME_BITS_LONG  20
// address space limits
`define SHORT_ADDR_LAST  10'h03f
`define LONG_ADDR_LAST   10'h38f
`define MEM_DEPTH        912
// header flag values
`define FLAG_SHORT       1'b0
`define FLAG_LONG        1'b1
`define DIR_READ         1'b0
`define DIR_WRITE        1'b1
// memory reset value
`define MEM_RESET        8'h00

`endif

// File: rtl/spi_slave_port.v
`include "spi_port_regs.vh"

// Behaviour
// RULE1: slave only, host supplies clock and select
// RULE2: host uses mode 0, clock idles low
// RULE3: host holds select low whole transaction
// RULE4: sample serial input on rising clock edge
// RULE5: change serial output on falling clock edge
// RULE6: output driven low while select high
// RULE7: short space, six address bits, 0 to 63
// RULE8: short header eight bits, first bit zero
// RULE9: short flag then six address bits, msb first
// RULE10: eighth bit: zero read, one write
// RULE11: long space ten bits, up to 0x38f
// RULE12: long header twelve bits, first bit one
// RULE13: long flag then ten address bits, msb first
// RULE14: twelfth bit: zero read, one write
// RULE15: memory is static ram behind the port
// RULE16: one data byte after header, msb first
// RULE17: select high abandons frame, resets counter
module spi_slave_port #(
	parameter DATA_W = `DATA_BITS,
	parameter DEPTH  = `MEM_DEPTH
) (
	input  wire              clk,
	input  wire              rstn,
	input  wire              sck,
	input  wire              cs_n,
	input  wire              sdi,
	output reg               sdo,
	output reg               wr_strobe,
	output reg  [9:0]        wr_addr,
	output reg  [DATA_W-1:0] wr_data
);

	localparam ADDR_W  = `LONG_ADDR_W;
	// frame phases
	localparam ST_IDLE = 3'b000;
	localparam ST_FLAG = 3'b001;
	localparam ST_ADDR = 3'b010;
	localparam ST_DIR  = 3'b011;
	localparam ST_DATA = 3'b100;
	localparam ST_DONE = 3'b101;

	// pins after two flip-flops
	wire              sck_s;
	wire              cs_s;
	wire              sdi_s;
	reg               sck_d;
	wire              sck_rise;
	wire              sck_fall;
	wire              selected;

	// frame state
	reg  [2:0]        state;
	reg  [2:0]        next_state;
	reg  [4:0]        bit_cnt;
	reg  [4:0]        next_bit_cnt;
	reg               is_long;
	reg               next_is_long;
	reg  [ADDR_W-1:0] addr;
	reg  [ADDR_W-1:0] next_addr;
	reg               is_write;
	reg               next_is_write;
	reg  [DATA_W-1:0] shift_in;
	reg  [DATA_W-1:0] next_shift_in;
	reg               commit;
	wire [4:0]        hdr_len;
	wire [4:0]        frame_len;
	wire              addr_ok;

	// read side
	reg  [DATA_W-1:0] shift_out;
	reg  [DATA_W-1:0] next_shift_out;
	reg               next_sdo;
	wire [DATA_W-1:0] mem_word;
	wire [DATA_W-1:0] rd_word;

	pin_sync #(
		.RESET_VAL (1'b0)
	) sck_sync (
		.clk  (clk),
		.rstn (rstn),
		.pin  (sck), // RULE1
		.q    (sck_s)
	);

	pin_sync #(
		.RESET_VAL (1'b1)
	) cs_sync (
		.clk  (clk),
		.rstn (rstn),
		.pin  (cs_n),
		.q    (cs_s)
	);

	pin_sync #(
		.RESET_VAL (1'b0)
	) sdi_sync (
		.clk  (clk),
		.rstn (rstn),
		.pin  (sdi),
		.q    (sdi_s)
	);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sck_d <= 1'b0;
		end else begin
			sck_d <= sck_s;
		end
	end

	assign sck_rise  = sck_s & ~sck_d; // RULE4
	assign sck_fall  = ~sck_s & sck_d; // RULE5
	assign selected  = ~cs_s;
	assign hdr_len   = is_long ? 5'd`LONG_HDR_BITS : 5'd`SHORT_HDR_BITS;
	assign frame_len = is_long ? 5'd`FRAME_BITS_LONG : 5'd`FRAME_BITS_SHORT;
	assign addr_ok   = (addr <= `LONG_ADDR_LAST); // RULE11
	assign rd_word   = addr_ok ? mem_word : {DATA_W{1'b0}};

	// frame decode, advanced on synchronised clock rises
	always @* begin
		next_state    = state;
		next_bit_cnt  = bit_cnt;
		next_is_long  = is_long;
		next_addr     = addr;
		next_is_write = is_write;
		next_shift_in = shift_in;
		commit        = 1'b0;
		if (!selected) begin
			next_state   = ST_IDLE; // RULE17
			next_bit_cnt = 5'd0;
			next_addr    = {ADDR_W{1'b0}};
		end else if (sck_rise) begin
			next_bit_cnt = bit_cnt + 5'd1;
			case (state)
				ST_IDLE, ST_FLAG: begin
					next_is_long = sdi_s; // RULE8 RULE12
					next_state   = ST_ADDR;
				end
				ST_ADDR: begin
					next_addr = {addr[ADDR_W-2:0], sdi_s}; // RULE9 RULE13
					if (bit_cnt == hdr_len - 5'd2) begin
						next_state = ST_DIR;
					end
				end
				ST_DIR: begin
					next_is_write = sdi_s; // RULE10 RULE14
					next_state    = ST_DATA;
				end
				ST_DATA: begin
					next_shift_in = {shift_in[DATA_W-2:0], sdi_s}; // RULE16
					if (bit_cnt == frame_len - 5'd1) begin
						next_state = ST_DONE;
						commit     = (is_write == `DIR_WRITE) && addr_ok;
					end
				end
				ST_DONE: begin
					next_bit_cnt = bit_cnt;
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end else if (state == ST_IDLE) begin
			next_state = ST_FLAG;
		end
	end

	// serial output, moved on synchronised clock falls
	always @* begin
		next_sdo       = sdo;
		next_shift_out = shift_out;
		if (!selected) begin
			next_sdo       = 1'b0; // RULE6
			next_shift_out = {DATA_W{1'b0}};
		end else if (sck_fall) begin // RULE5
			if (state == ST_DATA && bit_cnt == hdr_len && is_write == `DIR_READ) begin
				next_sdo       = rd_word[DATA_W-1];
				next_shift_out = {rd_word[DATA_W-2:0], 1'b0};
			end else begin
				next_sdo       = shift_out[DATA_W-1];
				next_shift_out = {shift_out[DATA_W-2:0], 1'b0};
			end
		end
	end

	// frame registers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state    <= ST_IDLE;
			bit_cnt  <= 5'd0;
			is_long  <= 1'b0;
			addr     <= {ADDR_W{1'b0}};
			is_write <= 1'b0;
			shift_in <= {DATA_W{1'b0}};
		end else begin
			state    <= next_state;
			bit_cnt  <= next_bit_cnt;
			is_long  <= next_is_long;
			addr     <= next_addr;
			is_write <= next_is_write;
			shift_in <= next_shift_in;
		end
	end

	// read registers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sdo       <= 1'b0;
			shift_out <= {DATA_W{1'b0}};
		end else begin
			sdo       <= next_sdo;
			shift_out <= next_shift_out;
		end
	end

	// write report towards the core
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_strobe <= 1'b0;
			wr_addr   <= 10'h000;
			wr_data   <= {DATA_W{1'b0}};
		end else begin
			wr_strobe <= commit;
			if (commit) begin
				wr_addr <= addr;
				wr_data <= next_shift_in;
			end
		end
	end

	// static ram; short space aliases 0x000..0x03f
	byte_store #(
		.DATA_W (DATA_W),
		.DEPTH  (DEPTH),
		.ADDR_W (ADDR_W)
	) store (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (commit), // RULE15 RULE7
		.wr_addr (addr),
		.wr_data (next_shift_in),
		.rd_addr (addr),
		.rd_data (mem_word)
	);

endmodule // spi_slave_port

module pin_sync #(
	parameter RESET_VAL = 1'b0
) (
	input  wire clk,
	input  wire rstn,
	input  wire pin,
	output reg  q
);

	// first stage may go metastable; only q is read
	reg meta;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta <= RESET_VAL;
			q    <= RESET_VAL;
		end else begin
			meta <= pin;
			q    <= meta;
		end
	end

endmodule // pin_sync

module byte_store #(
	parameter DATA_W = `DATA_BITS,
	parameter DEPTH  = `MEM_DEPTH,
	parameter ADDR_W = `LONG_ADDR_W
) (
	input  wire              clk,
	input  wire              rstn,
	input  wire              wr_en,
	input  wire [ADDR_W-1:0] wr_addr,
	input  wire [DATA_W-1:0] wr_data,
	input  wire [ADDR_W-1:0] rd_addr,
	output wire [DATA_W-1:0] rd_data
);

	reg     [DATA_W-1:0] mem [0:DEPTH-1];
	integer              i;

	// cells past the top of the array read as zero
	assign rd_data = (rd_addr < DEPTH) ? mem[rd_addr] : {DATA_W{1'b0}};

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem[i] <= `MEM_RESET;
			end
		end else if (wr_en && wr_addr < DEPTH) begin
			mem[wr_addr] <= wr_data;
		end
	end

endmodule // byte_store

// File: verification/spi_host_model.sv
module spi_host_model (
	input  logic sdo,
	output logic sck  = 1'h0,
	output logic cs_n = 1'h1,
	output logic sdi  = 1'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic xfer(input logic [19:0] f, input int n, output logic [7:0] rd);
		cs_n = 1'h0;
		#24;
		for (int i = n - 1; i >= 0; i--) begin
			sdi = f[i];
			#24 sck = 1'h1;
			rd = {rd[6:0], sdo};
			#24 sck = 1'h0;
		end
		cs_n = 1'h1;
		sdi = ~sdi;
		#60;
	endtask
endmodule // spi_host_model

// File: verification/spi_slave_port_assertions.sv
module spi_slave_port_checker (
	input logic       clk,
	input logic       rstn,
	input logic       sck,
	input logic       cs_n,
	input logic       sdo,
	input logic       wr_strobe,
	input logic [9:0] wr_addr,
	input logic [7:0] wr_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_idle_low; cs_n [*4] |-> !sdo; endproperty
	a_idle_low: assert property (p_idle_low) else $error("sdo not low");
	property p_pulse; wr_strobe |=> !wr_strobe; endproperty
	a_pulse: assert property (p_pulse) else $error("strobe too long");
	property p_addr; $changed(wr_addr) |-> wr_strobe; endproperty
	a_addr: assert property (p_addr) else $error("addr moved");
	property p_data; $changed(wr_data) |-> wr_strobe; endproperty
	a_data: assert property (p_data) else $error("data moved");
	property p_range; wr_strobe |-> wr_addr <= 10'h38f; endproperty
	a_range: assert property (p_range) else $error("addr range");
	property p_edge; $rose(sdo) |-> !sck; endproperty
	a_edge: assert property (p_edge) else $error("sdo edge");
endmodule // spi_slave_port_checker
bind spi_slave_port spi_slave_port_checker chk_i (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .sdo(sdo),
	.wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));

// File: verification/spi_slave_short_long_access_tb_top.sv
module spi_slave_short_long_access_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'h0, rstn = 1'h0;
	wire        sck, cs_n, sdi, sdo, wr_strobe;
	wire  [9:0] wr_addr;
	wire  [7:0] wr_data;
	logic [7:0] rd;
	int         errors = 0, num_checks = 0, strobes = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) if (wr_strobe === 1'h1) strobes++;
	spi_host_model host (.sdo(sdo), .sck(sck), .cs_n(cs_n), .sdi(sdi));
	spi_slave_port DUT (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
		.wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));
	task chk(input string n, input logic [9:0] e, input logic [9:0] s);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task tally_and_finish;
		$display("errors %0d checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task t_short;
		host.xfer({4'h0, 1'h0, 6'h3f, 1'h1, 8'ha5}, 16, rd);
		chk("wr_addr", 10'h03f, wr_addr);
		chk("wr_data", 10'h0a5, {2'h0, wr_data});
		host.xfer({1'h1, 10'h03f, 1'h0, 8'h00}, 20, rd);
		chk("rd", 10'h0a5, {2'h0, rd});
	endtask
	task t_long;
		host.xfer({1'h1, 10'h38f, 1'h1, 8'h3c}, 20, rd);
		chk("wr_addr", 10'h38f, wr_addr);
		host.xfer({1'h1, 10'h390, 1'h1, 8'h77}, 20, rd);
		host.xfer({1'h1, 10'h38f, 1'h0, 8'h00}, 20, rd);
		chk("rd", 10'h03c, {2'h0, rd});
		chk("strobes", 10'h002, strobes[9:0]);
	endtask
	task t_abort;
		host.xfer({10'h0, 1'h1, 9'h07f}, 10, rd);
		host.xfer({4'h0, 1'h0, 6'h3f, 1'h0, 8'h00}, 16, rd);
		chk("rd", 10'h0a5, {2'h0, rd});
		chk("strobes", 10'h002, strobes[9:0]);
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rstn = 1'h1;
		repeat (4) @(negedge clk);
		t_short;
		t_long;
		t_abort;
		tally_and_finish;
	end
	initial begin
		#50us;
		errors++;
		tally_and_finish;
	end
endmodule // spi_slave_short_long_access_tb_top
